// *** logic/fpc_pkg.sv ***
package fpc_pkg;
    // register byte offsets on the axi4-lite slave
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] PROT_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // status word bit positions
    localparam int STAT_VIOL = 0;
    localparam int STAT_LOADED = 1;
    localparam int STAT_SCEN_LSB = 2;

    // array byte that holds the protection setting loaded at reset
    localparam logic [15:0] NV_PROT_ADDR = 16'hff0d;

    // window bounds; high start and low end indexed by the size code
    localparam logic [3:0][15:0] HIGH_START = {16'hc000, 16'he000, 16'hf000, 16'hf800};
    localparam logic [15:0] LOW_START = 16'h4000;
    localparam logic [3:0][15:0] LOW_END = {16'h5fff, 16'h4fff, 16'h47ff, 16'h43ff};

    // scenario index, looked up from {polarity, high disable, low disable}
    typedef logic [2:0] scen_t;
    localparam logic [7:0][2:0] SCEN_MAP_DEF = {3'h7, 3'h6, 3'h5, 3'h4,
                                                 3'h3, 3'h2, 3'h1, 3'h0};

    // allowed targets per source scenario, bit n set means scenario n allowed
    localparam logic [7:0][7:0] TRANS_OK = {8'hff, 8'h5a, 8'h3c, 8'h18,
                                            8'h08, 8'h0c, 8'h0a, 8'h0f};

    // protection register layout, msb first
    typedef struct packed {
        logic protect_polarity;
        logic spare_nonvolatile_flag;
        logic high_window_disable;
        logic [1:0] high_window_size;
        logic low_window_disable;
        logic [1:0] low_window_size;
    } array_protection_setting_s;

    // value held until the array byte arrives: whole array protected
    localparam logic [7:0] SETTING_RST = 8'h7f;

    // request from the command controller
    typedef struct packed {
        logic valid;
        logic mass_erase;
        logic [15:0] addr;
    } cmd_s;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } phase_e;
endpackage

// *** logic/flash_protection_control.sv ***
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module flash_protection_control #(
    parameter logic [7:0][2:0] SCEN_MAP = fpc_pkg::SCEN_MAP_DEF
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [fpc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [fpc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // array read port for the reset load
    output logic [15:0] nv_rd_addr,
    input wire logic [7:0] nv_rd_data,
    // command controller check
    input wire fpc_pkg::cmd_s cmd,
    output logic cmd_granted,
    output logic cmd_refused,
    output logic addr_protected,
    output logic protection_violation_flag
);

    typedef struct packed {
        fpc_pkg::phase_e phase;
        fpc_pkg::array_protection_setting_s setting;
        logic viol;
        logic aw_held;
        logic [fpc_pkg::ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic addr_prot;
        logic granted;
        logic refused;
        logic [15:0] nv_addr;
    } state_s;

    localparam state_s ST_RST = '{
        phase: fpc_pkg::ST_LOAD,
        setting: fpc_pkg::SETTING_RST,
        nv_addr: fpc_pkg::NV_PROT_ADDR,
        awready: 1'b1,
        wready: 1'b1,
        arready: 1'b1,
        addr_prot: 1'b1,
        default: '0
    };

    state_s state_reg;
    state_s state_next;

    // scenario index of a setting
    function automatic fpc_pkg::scen_t scen_of(fpc_pkg::array_protection_setting_s p);
        return SCEN_MAP[{p.protect_polarity, p.high_window_disable,
                         p.low_window_disable}];
    endfunction

    // protection of one array address under a setting
    function automatic logic prot_hit(fpc_pkg::array_protection_setting_s p,
                                      logic [15:0] a);
        logic in_hi;
        logic in_lo;
        in_hi = !p.high_window_disable &&
                (a >= fpc_pkg::HIGH_START[p.high_window_size]);
        in_lo = !p.low_window_disable && (a >= fpc_pkg::LOW_START) &&
                (a <= fpc_pkg::LOW_END[p.low_window_size]);
        // polarity swaps the meaning of the windows; with both windows off
        // this gives none protected or all protected
        if (p.protect_polarity) begin
            return in_hi || in_lo;
        end else begin
            return !(in_hi || in_lo);
        end
    endfunction

    // whole array open: polarity and both disables set
    function automatic logic all_open(fpc_pkg::array_protection_setting_s p);
        return p.protect_polarity && p.high_window_disable && p.low_window_disable;
    endfunction

    // candidate value of a software write, before the scenario check
    function automatic fpc_pkg::array_protection_setting_s apply_write(
        fpc_pkg::array_protection_setting_s cur,
        fpc_pkg::array_protection_setting_s w);
        fpc_pkg::array_protection_setting_s c;
        c = cur;
        c.protect_polarity = cur.protect_polarity & w.protect_polarity;
        c.spare_nonvolatile_flag = w.spare_nonvolatile_flag;
        c.high_window_disable = w.high_window_disable;
        c.low_window_disable = w.low_window_disable;
        if (cur.high_window_disable) begin
            c.high_window_size = w.high_window_size;
        end
        if (cur.low_window_disable) begin
            c.low_window_size = w.low_window_size;
        end
        return c;
    endfunction

    // next state: load, bus slave, command check
    always_comb begin
        fpc_pkg::array_protection_setting_s cand;
        logic viol_clr;
        logic viol_set;
        cand = state_reg.setting;
        viol_clr = 1'b0;
        viol_set = 1'b0;
        state_next = state_reg;
        state_next.granted = 1'b0;
        state_next.refused = 1'b0;

        // first cycle after reset takes the stored byte from the array
        if (state_reg.phase == fpc_pkg::ST_LOAD) begin
            state_next.setting = nv_rd_data;
            state_next.phase = fpc_pkg::ST_RUN;
        end

        // address and data may arrive in either order
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end

        // carry out a write once both halves are held
        if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = fpc_pkg::RESP_OKAY;
            if (state_reg.aw_addr == fpc_pkg::PROT_OFS) begin
                if (state_reg.w_strb[0] && state_reg.phase == fpc_pkg::ST_RUN) begin
                    cand = apply_write(state_reg.setting, state_reg.w_data[7:0]);
                    // an illegal target drops the whole byte
                    if (fpc_pkg::TRANS_OK[scen_of(state_reg.setting)][scen_of(cand)]) begin
                        state_next.setting = cand;
                    end
                end
            end else if (state_reg.aw_addr == fpc_pkg::STAT_OFS) begin
                viol_clr = state_reg.w_strb[0] && state_reg.w_data[fpc_pkg::STAT_VIOL];
            end else begin
                state_next.bresp = fpc_pkg::RESP_SLVERR;
            end
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        // each ready stays low while its own half waits or a response is pending
        state_next.awready = !state_next.aw_held && !state_next.bvalid;
        state_next.wready = !state_next.w_held && !state_next.bvalid;

        // reads answer one cycle after the address is taken
        if (s_axi_arvalid && state_reg.arready) begin
            state_next.arready = 1'b0;
            state_next.rvalid = 1'b1;
            state_next.rresp = fpc_pkg::RESP_OKAY;
            state_next.rdata = '0;
            if (s_axi_araddr == fpc_pkg::PROT_OFS) begin
                state_next.rdata[7:0] = state_reg.setting;
            end else if (s_axi_araddr == fpc_pkg::STAT_OFS) begin
                state_next.rdata[fpc_pkg::STAT_VIOL] = state_reg.viol;
                state_next.rdata[fpc_pkg::STAT_LOADED] =
                    (state_reg.phase == fpc_pkg::ST_RUN);
                state_next.rdata[fpc_pkg::STAT_SCEN_LSB +: 3] = scen_of(state_reg.setting);
            end else begin
                state_next.rresp = fpc_pkg::RESP_SLVERR;
            end
        end
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
            state_next.arready = 1'b1;
        end

        // address check, registered so the output comes from a flop
        state_next.addr_prot = prot_hit(state_reg.setting, cmd.addr);
        if (cmd.valid) begin
            if (state_reg.phase != fpc_pkg::ST_RUN) begin
                state_next.refused = 1'b1;
            end else if (cmd.mass_erase ? !all_open(state_reg.setting)
                                        : prot_hit(state_reg.setting, cmd.addr)) begin
                state_next.refused = 1'b1;
                viol_set = 1'b1;
            end else begin
                state_next.granted = 1'b1;
            end
        end
        // a new violation beats a clear in the same cycle
        state_next.viol = (state_reg.viol && !viol_clr) || viol_set;
    end

    // single state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign s_axi_rvalid = state_reg.rvalid;
    assign nv_rd_addr = state_reg.nv_addr;
    assign cmd_granted = state_reg.granted;
    assign cmd_refused = state_reg.refused;
    assign addr_protected = state_reg.addr_prot;
    assign protection_violation_flag = state_reg.viol;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    wire logic running = (state_reg.phase == fpc_pkg::ST_RUN);
    wire logic prot_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid
                            && state_reg.aw_addr == fpc_pkg::PROT_OFS
                            && state_reg.w_strb[0] && running;
    wire fpc_pkg::array_protection_setting_s w_cand =
        apply_write(state_reg.setting, state_reg.w_data[7:0]);

    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence prot_read;
        ar_take ##0 (s_axi_araddr == fpc_pkg::PROT_OFS);
    endsequence

    sequence both_held;
        state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    endsequence

    sequence bad_cmd;
        cmd.valid && running && (cmd.mass_erase ? !all_open(state_reg.setting)
                                               : prot_hit(state_reg.setting, cmd.addr));
    endsequence

    // polarity can only fall once running
    polarity_one_way_a: assert property (
        (running && !state_reg.setting.protect_polarity) |=>
        !state_reg.setting.protect_polarity)
        else $error("polarity set again after being cleared");

    // high size frozen while its window is enabled
    high_size_lock_a: assert property (
        (running && !state_reg.setting.high_window_disable) |=>
        $stable(state_reg.setting.high_window_size))
        else $error("high size changed while window enabled");

    // low size frozen while its window is enabled
    low_size_lock_a: assert property (
        (running && !state_reg.setting.low_window_disable) |=>
        $stable(state_reg.setting.low_window_size))
        else $error("low size changed while window enabled");

    // every change lands on an allowed scenario
    scen_legal_a: assert property (
        (running && $past(running)) |->
        fpc_pkg::TRANS_OK[scen_of($past(state_reg.setting))][scen_of(state_reg.setting)])
        else $error("illegal scenario transition");

    // writes with a legal target are stored
    legal_write_a: assert property (
        (prot_write && fpc_pkg::TRANS_OK[scen_of(state_reg.setting)][scen_of(w_cand)]) |=>
        state_reg.setting == $past(w_cand))
        else $error("legal protection write not stored");

    // writes with an illegal target change nothing
    illegal_drop_a: assert property (
        (prot_write && !fpc_pkg::TRANS_OK[scen_of(state_reg.setting)][scen_of(w_cand)]) |=>
        $stable(state_reg.setting))
        else $error("illegal protection write took effect");

    // reset load copies the array byte; the release edge itself still holds reset state
    reset_load_a: assert property (
        (aresetn && state_reg.phase == fpc_pkg::ST_LOAD) |=>
        running && state_reg.setting == $past(nv_rd_data))
        else $error("protection byte not loaded after reset");

    // read answer carries the enforced setting
    read_back_a: assert property (
        prot_read |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(state_reg.setting)
                      && s_axi_rdata[31:8] == '0)
        else $error("protection read mismatch");

    // protected requests while running are refused and raise the flag one cycle later
    refuse_flag_a: assert property (
        bad_cmd |=> cmd_refused && !cmd_granted && protection_violation_flag)
        else $error("protected request not refused");

    // mass erase granted whenever wholly open
    mass_gate_a: assert property (
        (cmd.valid && cmd.mass_erase && running && all_open(state_reg.setting)) |=>
        cmd_granted && !cmd_refused)
        else $error("open mass erase refused");

    // all windows off: polarity alone decides
    full_state_a: assert property (
        (running && state_reg.setting.high_window_disable &&
         state_reg.setting.low_window_disable && $stable(cmd.addr) &&
         $stable(state_reg.setting)) |->
        addr_protected == !state_reg.setting.protect_polarity)
        else $error("window-off protection wrong");

    // write response within one cycle of both halves
    write_resp_a: assert property (
        both_held |=> s_axi_bvalid ##0 !s_axi_awready ##0 !s_axi_wready)
        else $error("write response missing");
endmodule

`default_nettype wire

// *** testbench/tb_flash_protection_control.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_flash_protection_control;
    logic aclk;
    logic aresetn;
    logic [3:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [3:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic [15:0] nv_rd_addr;
    logic [7:0] nv_rd_data;
    fpc_pkg::cmd_s cmd;
    logic cmd_granted;
    logic cmd_refused;
    logic addr_protected;
    logic protection_violation_flag;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 32'h821db0ef;
    // bit n of entry f set: scenario f may move to scenario n
    logic [7:0] ok_to [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
    logic [7:0] set_m;
    logic flag_m;
    logic [7:0] nv;
    logic [7:0] w;
    logic [31:0] d;
    logic [1:0] r;

    flash_protection_control flash_protection_control_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .nv_rd_addr(nv_rd_addr), .nv_rd_data(nv_rd_data), .cmd(cmd),
        .cmd_granted(cmd_granted), .cmd_refused(cmd_refused),
        .addr_protected(addr_protected), .protection_violation_flag(protection_violation_flag)
    );

    // 50 mhz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // hang guard: generous against roughly 3k cycles of traffic
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [15:0] hi_start(input logic [1:0] c);
        case (c)
            2'h0: return 16'hf800;
            2'h1: return 16'hf000;
            2'h2: return 16'he000;
            default: return 16'hc000;
        endcase
    endfunction

    function automatic logic [15:0] lo_end(input logic [1:0] c);
        case (c)
            2'h0: return 16'h43ff;
            2'h1: return 16'h47ff;
            2'h2: return 16'h4fff;
            default: return 16'h5fff;
        endcase
    endfunction

    // polarity one protects the enabled windows, zero leaves only them open
    function automatic logic prot(input logic [7:0] s, input logic [15:0] a);
        logic in_win;
        in_win = (!s[5] && a >= hi_start(s[4:3]))
            || (!s[2] && a >= 16'h4000 && a <= lo_end(s[1:0]));
        return s[7] ? in_win : !in_win;
    endfunction

    // sizes stick once their window is enabled; whole byte dropped on a bad move
    function automatic logic [7:0] model_wr(input logic [7:0] o, input logic [7:0] n);
        logic [7:0] c;
        c = n;
        c[7] = o[7] & n[7];
        if (!o[5]) c[4:3] = o[4:3];
        if (!o[2]) c[1:0] = o[1:0];
        return ok_to[{o[7], o[5], o[2]}][{c[7], c[5], c[2]}] ? c : o;
    endfunction

    // window edges are where an off-by-one shows, so favour them
    function automatic logic [15:0] pick_addr(input logic [7:0] s);
        case ($unsigned($random(seed)) % 8)
            0: return hi_start(s[4:3]);
            1: return hi_start(s[4:3]) - 16'h1;
            2: return lo_end(s[1:0]);
            3: return lo_end(s[1:0]) + 16'h1;
            4: return 16'h4000;
            5: return 16'h3fff;
            6: return 16'hffff;
            default: return 16'($random(seed));
        endcase
    endfunction

    task automatic do_reset(input logic [7:0] v);
        nv_rd_data <= v;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    // bready stays high throughout, so this task drives only address, data, strobe and valid lines
    task automatic axi_write(input logic [3:0] a, input logic [31:0] dv, input logic [3:0] st,
                             output logic [1:0] rs);
        bit aw = 0;
        bit wd = 0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= dv;
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        while (!(aw && wd)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready === 1'b1) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] dv, output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        dv = s_axi_rdata;
        rs = s_axi_rresp;
    endtask

    // one-cycle request, answer and protection seen one edge later
    task automatic cmd_try(input logic [15:0] a, input logic m);
        logic exp_ref;
        exp_ref = m ? !(set_m[7] & set_m[5] & set_m[2]) : prot(set_m, a);
        cmd.valid <= 1'b1;
        cmd.mass_erase <= m;
        cmd.addr <= a;
        @(posedge aclk);
        cmd.valid <= 1'b0;
        @(posedge aclk);
        check("addr_protected", addr_protected, prot(set_m, a));
        check("cmd_refused", cmd_refused, exp_ref);
        check("cmd_granted", cmd_granted, !exp_ref);
        flag_m = flag_m | exp_ref;
        check("violation_flag", protection_violation_flag, flag_m);
    endtask

    // every source scenario against every target, then random traffic
    initial begin
        aresetn = 1'b0;
        s_axi_awaddr = 4'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = 4'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
        nv_rd_data = 8'h0;
        cmd = '0;
        for (int k = 0; k < 8; k++) begin
            for (int t = 0; t < 8; t++) begin
                nv = 8'($random(seed)) | 8'h40;
                {nv[7], nv[5], nv[2]} = 3'(k);
                do_reset(nv);
                set_m = nv;
                flag_m = 1'b0;
                check("nv_rd_addr", nv_rd_addr, 32'h0000ff0d);
                axi_read(fpc_pkg::PROT_OFS, d, r);
                check("setting_loaded", d, {24'h0, nv});
                for (int j = 0; j < 4; j++) begin
                    w = 8'($random(seed)) | 8'h40;
                    if (j == 0) {w[7], w[5], w[2]} = 3'(t);
                    axi_write(fpc_pkg::PROT_OFS, {24'h0, w}, 4'hf, r);
                    set_m = model_wr(set_m, w);
                    check("write_resp", r, fpc_pkg::RESP_OKAY);
                    axi_read(fpc_pkg::PROT_OFS, d, r);
                    check("setting", d, {24'h0, set_m});
                    cmd_try(pick_addr(set_m), ($random(seed) & 3) == 0);
                end
                axi_read(fpc_pkg::STAT_OFS, d, r);
                check("status", d, {27'h0, set_m[7], set_m[5], set_m[2], 1'b1, flag_m});
                axi_write(fpc_pkg::STAT_OFS, 32'h1, 4'hf, r);
                flag_m = 1'b0;
                axi_read(fpc_pkg::STAT_OFS, d, r);
                check("status_cleared", d[0], 1'b0);
            end
        end
        // lane zero off, then unmapped places: no effect on the setting
        axi_write(fpc_pkg::PROT_OFS, 32'h0, 4'he, r);
        axi_write(4'h8, 32'h0, 4'hf, r);
        check("unmapped_bresp", r, fpc_pkg::RESP_SLVERR);
        axi_read(4'hc, d, r);
        check("unmapped_rresp", r, fpc_pkg::RESP_SLVERR);
        check("unmapped_rdata", d, 32'h0);
        axi_read(fpc_pkg::PROT_OFS, d, r);
        check("setting_kept", d, {24'h0, set_m});
        summarize();
    end
endmodule

`default_nettype wire
